//--- src/serial_channel_map.svh
// Register offsets, field positions, idle read value and counts of the serial channel
`ifndef SERIAL_CHANNEL_MAP_SVH
`define SERIAL_CHANNEL_MAP_SVH
`define OFF_DATA 3'h0
`define OFF_CTRL 3'h1
`define OFF_MODE 3'h2
`define OFF_RATE 3'h3
`define CTRL_EVEN 6
`define CTRL_PAR_EN 5
`define CTRL_HSE 0
`define MODE_TXN 7
`define MODE_RXEN 6
`define MODE_WAKE 4
`define MODE_SM_LSB 2
`define MODE_CLK_SEL_LSB 0
`define RATE_LSB 6
`define RDATA_IDLE 8'h00
`define RX_SAMPLE_FIRST 4'h6
`define RX_SAMPLE_LAST 4'h8
`define BIT_LAST 4'hf
`define IO_EDGE 3'h3
`define IO_LAST 3'h7
`define IO_BITS 4'h8
`endif

//--- src/serial_channel_pkg.sv
// Types shared by the serial channel design
package serial_channel_pkg;
	typedef enum logic [1:0] {MODE_IO = 2'b00, MODE_UART7 = 2'b01, MODE_UART8 = 2'b10,
		MODE_UART9 = 2'b11} chan_mode_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
		RX_STOP = 2'b11} rx_state_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	typedef struct packed {
		logic [8:0] presc;
		logic base_div;
		logic int_div;
		logic rx_s1;
		logic rx_s2;
		logic cts_s1;
		logic cts_s2;
		logic [1:0] rate;
		logic tx_ninth;
		logic rx_en;
		logic wake_filt;
		chan_mode_t mode;
		logic [1:0] clk_sel;
		logic even;
		logic par_en;
		logic hse;
		rx_state_t rx_st;
		logic [3:0] rx_cnt;
		logic [2:0] vote;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
		logic [7:0] rbuf;
		logic ninth;
		logic full;
		logic ovr;
		logic par_err;
		logic ferr;
		logic rts;
		logic [3:0] tx_cnt;
		logic [7:0] tdata;
		logic tx_pend;
		logic tx_busy;
		logic [10:0] tx_sh;
		logic [3:0] tx_left;
		logic tx_low;
		logic io_busy;
		logic io_rx;
		logic io_tx;
		logic [2:0] io_div;
		logic [3:0] io_bits;
		logic sclk_low;
		logic [7:0] rdata;
		logic rx_int;
		logic tx_int;
	} chan_state_t;
endpackage

//--- src/serial_channel_uart_core.sv
// Serial channel: baud generation, UART and shift-register modes, handshake, parity
// How it works
// - Rate field picks prescaler tap 256/64/16/4.
// - Clock select 01 passes, 11 halves baud.
// - Shift mode drives clock at system/8.
// - Clock select picks baud, internal or timer.
// - Receiver counts sixteen serial ticks per bit.
// - Bit value is majority of ticks 7-9.
// - Start needs two of three low samples.
// - Shift mode samples and shifts on rising clock.
// - Finished frame moves to buffer, raises receive event.
// - Overrun keeps old buffer, drops new frame.
// - Control bit 7 holds parity or ninth bit.
// - Wake-up filter in 9-bit mode passes only ninth-bit-one frames.
// - Transmit bit clock every sixteen serial ticks.
// - Written data starts on next transmit bit clock.
// - Handshake raises request line after last bit.
// - Reading received data lowers request line.
// - Clear-to-send high halts after current frame.
// - LSB first; transmit event when all sent.
// - Parity only in 7/8-bit modes, even/odd.
// - Transmit parity goes to bit 7 or 8.
// - Receive parity mismatch sets parity error flag.
// - Overrun, parity, framing flags in bits 4,3,2.
// - Reading control register clears error flags.
`include "serial_channel_map.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_channel_uart_core import serial_channel_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire bus_req_t bus_req,
	output logic [7:0] rdata,
	// Serial pins
	input wire logic rxd,
	input wire logic cts,
	output logic txd,
	output logic sclk,
	output logic rts,
	// Timer match pulse, same clock
	input wire logic timer2_match,
	// Event pulses toward the CPU
	output logic receive_interrupt,
	output logic transmit_interrupt
);
	chan_state_t s_reg; // All state
	chan_state_t s_next; // Next state
	logic baud_tick; // Baud generator output pulse
	logic sio_tick; // Basic serial clock pulse
	logic uart; // Any UART mode
	logic tx_bit_clk; // Transmit bit clock pulse
	logic bit_val; // Majority of the three samples
	logic rx_done; // Last payload bit received
	logic rx_take; // Frame passes the wake-up filter
	logic [3:0] rx_len; // Payload bits per frame
	logic [8:0] rx_shin; // Shift register after the current bit
	logic [8:0] rx_d; // Received payload, right aligned
	logic rx_pexp; // Parity expected from received data
	logic [8:0] tx_pay; // Payload to send
	logic [10:0] tx_fr; // Whole frame to send
	logic rd_data; // Read of the data buffer
	logic rd_ctrl; // Read of the control register

	// Prescaler tap chosen by the rate field
	function automatic logic tap_hit(input logic [8:0] p, input logic [1:0] r);
		case (r)
			2'b00: tap_hit = (p[7:0] == 8'hff);
			2'b01: tap_hit = (p[5:0] == 6'h3f);
			2'b10: tap_hit = (p[3:0] == 4'hf);
			default: tap_hit = (p[1:0] == 2'h3);
		endcase
	endfunction

	// Two of three vote
	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Parity bit over eight bits, even or odd
	function automatic logic parity8(input logic [7:0] d, input logic ev);
		parity8 = ev ? ^d : ~^d;
	endfunction

	// Payload length; parity only adds a bit in the 7- and 8-bit modes
	function automatic logic [3:0] frame_len(input chan_mode_t m, input logic p);
		case (m)
			MODE_UART7: frame_len = 4'd7 + {3'b000, p};
			MODE_UART8: frame_len = 4'd8 + {3'b000, p};
			MODE_UART9: frame_len = 4'd9;
			default: frame_len = 4'd8;
		endcase
	endfunction

	// Start bit, payload LSB first, stop bit and idle ones
	function automatic logic [10:0] tx_frame(input logic [8:0] p, input logic [3:0] len);
		tx_frame = 11'h7fe;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < len) begin
				tx_frame[i + 1] = p[i];
			end
		end
	endfunction

	// Whole channel: register reads first, hardware events next, writes last, so an event wins over a read clear
	always_comb begin
		s_next = s_reg;
		s_next.rx_int = 1'b0;
		s_next.tx_int = 1'b0;
		s_next.rdata = `RDATA_IDLE;
		// Pin synchronisers
		s_next.rx_s1 = rxd;
		s_next.rx_s2 = s_reg.rx_s1;
		s_next.cts_s1 = cts;
		s_next.cts_s2 = s_reg.cts_s1;
		// Prescaler and baud generator
		s_next.presc = s_reg.presc + 9'h001;
		baud_tick = tap_hit(s_reg.presc, s_reg.rate);
		if (baud_tick) begin
			s_next.base_div = ~s_reg.base_div;
		end
		s_next.int_div = ~s_reg.int_div;
		// Basic serial clock source
		case (s_reg.clk_sel)
			2'b00: sio_tick = timer2_match;
			2'b01: sio_tick = baud_tick;
			2'b10: sio_tick = s_reg.int_div;
			default: sio_tick = baud_tick & s_reg.base_div;
		endcase
		uart = (s_reg.mode != MODE_IO);
		rd_data = bus_req.rd && (bus_req.addr == `OFF_DATA);
		rd_ctrl = bus_req.rd && (bus_req.addr == `OFF_CTRL);
		// Register reads; data and flags are consumed by the read
		if (bus_req.rd) begin
			case (bus_req.addr)
				`OFF_DATA: begin
					s_next.rdata = s_reg.rbuf;
					s_next.full = 1'b0;
					s_next.rts = 1'b0;
				end
				`OFF_CTRL: begin
					s_next.rdata = {s_reg.ninth, s_reg.even, s_reg.par_en, s_reg.ovr,
						s_reg.par_err, s_reg.ferr, 1'b0, s_reg.hse};
					s_next.ovr = 1'b0;
					s_next.par_err = 1'b0;
					s_next.ferr = 1'b0;
				end
				`OFF_MODE: begin
					s_next.rdata = {s_reg.tx_ninth, s_reg.rx_en, 1'b0, s_reg.wake_filt,
						s_reg.mode, s_reg.clk_sel};
				end
				`OFF_RATE: begin
					s_next.rdata = {s_reg.rate, 6'h00};
				end
				default: begin
					s_next.rdata = `RDATA_IDLE; // Unmapped reads as zero
				end
			endcase
		end
		// UART receiver, one step per basic serial clock
		bit_val = maj3(s_reg.vote);
		rx_len = frame_len(s_reg.mode, s_reg.par_en);
		rx_shin = {bit_val, s_reg.rx_sh[8:1]};
		rx_d = rx_shin >> (4'd9 - rx_len);
		rx_done = 1'b0;
		if (uart && sio_tick) begin
			case (s_reg.rx_st)
				RX_IDLE: begin
					// The falling edge is pulse one of the start bit
					if (s_reg.rx_en && !s_reg.rx_s2) begin
						s_next.rx_st = RX_START;
						s_next.rx_cnt = 4'h1;
					end
				end
				default: begin
					s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
					if (s_reg.rx_cnt >= `RX_SAMPLE_FIRST && s_reg.rx_cnt <= `RX_SAMPLE_LAST) begin
						s_next.vote = {s_reg.vote[1:0], s_reg.rx_s2};
					end
					if (s_reg.rx_cnt == `BIT_LAST) begin
						case (s_reg.rx_st)
							RX_START: begin
								// Noise spike: fewer than two low samples
								if (bit_val) begin
									s_next.rx_st = RX_IDLE;
								end else begin
									s_next.rx_st = RX_DATA;
									s_next.rx_bits = 4'h0;
								end
							end
							RX_DATA: begin
								s_next.rx_sh = rx_shin;
								s_next.rx_bits = s_reg.rx_bits + 4'h1;
								if (s_reg.rx_bits + 4'h1 == rx_len) begin
									rx_done = 1'b1;
									s_next.rx_st = RX_STOP;
								end
							end
							default: begin
								// Stop bit must read high
								if (!bit_val) begin
									s_next.ferr = 1'b1;
								end
								s_next.rx_st = RX_IDLE;
							end
						endcase
					end
				end
			endcase
		end
		// Frame completion into the holding buffer
		rx_take = rx_done && !(s_reg.mode == MODE_UART9 && s_reg.wake_filt && !rx_d[8]);
		rx_pexp = parity8((s_reg.mode == MODE_UART7) ? {1'b0, rx_d[6:0]} : rx_d[7:0],
			s_reg.even);
		if (rx_done && s_reg.hse) begin
			s_next.rts = 1'b1;
		end
		if (rx_take) begin
			if (s_reg.full) begin
				s_next.ovr = 1'b1;
			end else begin
				s_next.full = 1'b1;
				s_next.rx_int = 1'b1;
				if (s_reg.mode == MODE_UART7) begin
					s_next.rbuf = {s_reg.par_en & rx_d[7], rx_d[6:0]};
				end else begin
					s_next.rbuf = rx_d[7:0];
					s_next.ninth = rx_d[8];
				end
				if (s_reg.par_en && s_reg.mode != MODE_UART9) begin
					if (rx_pexp != ((s_reg.mode == MODE_UART7) ? rx_d[7] : rx_d[8])) begin
						s_next.par_err = 1'b1;
					end
				end
			end
		end
		// UART transmitter
		tx_bit_clk = uart && sio_tick && (s_reg.tx_cnt == `BIT_LAST);
		if (uart && sio_tick) begin
			s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
		end
		case (s_reg.mode)
			MODE_UART7: tx_pay = {1'b0, s_reg.par_en & parity8({1'b0, s_reg.tdata[6:0]}, s_reg.even),
				s_reg.tdata[6:0]};
			MODE_UART8: tx_pay = {s_reg.par_en ? parity8(s_reg.tdata, s_reg.even) : s_reg.tx_ninth,
				s_reg.tdata};
			default: tx_pay = {s_reg.tx_ninth, s_reg.tdata};
		endcase
		tx_fr = tx_frame(tx_pay, rx_len);
		if (tx_bit_clk) begin
			if (s_reg.tx_busy) begin
				if (s_reg.tx_left != 4'h0) begin
					s_next.tx_low = ~s_reg.tx_sh[0];
					s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
					s_next.tx_left = s_reg.tx_left - 4'h1;
				end else begin
					// Stop bit has stood a full bit time
					s_next.tx_busy = 1'b0;
					s_next.tx_int = 1'b1;
				end
			end else if (s_reg.tx_pend && !s_reg.cts_s2) begin
				// Held while clear-to-send is high; the finished frame already raised its event
				s_next.tx_low = ~tx_fr[0];
				s_next.tx_sh = {1'b1, tx_fr[10:1]};
				s_next.tx_left = rx_len + 4'h1;
				s_next.tx_busy = 1'b1;
				s_next.tx_pend = 1'b0;
			end
		end
		// Shift-register interface mode; one clock serves both directions
		if (!uart) begin
			if (!s_reg.io_busy) begin
				if (s_reg.tx_pend || (s_reg.rx_en && !s_reg.full)) begin
					s_next.io_busy = 1'b1;
					s_next.io_div = 3'h0;
					s_next.io_bits = 4'h0;
					s_next.io_tx = s_reg.tx_pend;
					s_next.io_rx = s_reg.rx_en && !s_reg.full;
					s_next.tx_sh = {3'b111, s_reg.tdata};
					s_next.tx_pend = 1'b0;
				end
			end else begin
				s_next.io_div = s_reg.io_div + 3'h1;
				if (s_reg.io_div == `IO_EDGE) begin
					// Rising shift clock edge: shift out and sample together
					if (s_reg.io_tx) begin
						s_next.tx_low = ~s_reg.tx_sh[0];
					end
					s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
					s_next.rx_sh = {s_reg.rx_s2, s_reg.rx_sh[8:1]};
					s_next.io_bits = s_reg.io_bits + 4'h1;
				end
				if (s_reg.io_div == `IO_LAST && s_reg.io_bits == `IO_BITS) begin
					s_next.io_busy = 1'b0;
					s_next.tx_low = 1'b0;
					s_next.tx_int = s_reg.io_tx;
					if (s_reg.io_rx) begin
						s_next.rbuf = s_reg.rx_sh[8:1];
						s_next.full = 1'b1;
						s_next.rx_int = 1'b1;
					end
				end
			end
		end
		// Shift clock high in the second half of each eight-cycle period, idle high
		s_next.sclk_low = s_next.io_busy & ~s_next.io_div[2];
		// Register writes last, so a write in a load cycle is not lost
		if (bus_req.wr) begin
			case (bus_req.addr)
				`OFF_DATA: begin
					s_next.tdata = bus_req.wdata;
					s_next.tx_pend = 1'b1;
				end
				`OFF_CTRL: begin
					s_next.even = bus_req.wdata[`CTRL_EVEN];
					s_next.par_en = bus_req.wdata[`CTRL_PAR_EN];
					s_next.hse = bus_req.wdata[`CTRL_HSE];
				end
				`OFF_MODE: begin
					s_next.tx_ninth = bus_req.wdata[`MODE_TXN];
					s_next.rx_en = bus_req.wdata[`MODE_RXEN];
					s_next.wake_filt = bus_req.wdata[`MODE_WAKE];
					s_next.mode = chan_mode_t'(bus_req.wdata[`MODE_SM_LSB +: 2]);
					s_next.clk_sel = bus_req.wdata[`MODE_CLK_SEL_LSB +: 2];
				end
				`OFF_RATE: begin
					s_next.rate = bus_req.wdata[`RATE_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	// State register; lines idle high through the inverted storage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops
	assign rdata = s_reg.rdata;
	assign txd = ~s_reg.tx_low;
	assign sclk = ~s_reg.sclk_low;
	assign rts = s_reg.rts;
	assign receive_interrupt = s_reg.rx_int;
	assign transmit_interrupt = s_reg.tx_int;

	// Checks on the channel behaviour
	AST_TAP_FAST: assert property (@(posedge clk) disable iff (!arst_n)
		(s_reg.clk_sel == 2'b01 && s_reg.rate == 2'b11 && sio_tick) |-> s_reg.presc[1:0] == 2'h3)
		else $error("fastest tap ticked off its prescaler count");
	AST_HALF_DIV: assert property (@(posedge clk) disable iff (!arst_n)
		(s_reg.clk_sel == 2'b11 && sio_tick && !bus_req.wr)
		|=> (!sio_tick || s_reg.clk_sel != 2'b11) [*7])
		else $error("halved baud clock ticked too soon");
	AST_SCLK_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
		($rose(sclk) && s_reg.io_bits < `IO_BITS) |=> sclk [*3] ##1 !sclk)
		else $error("shift clock high phase not four cycles");
	AST_START_NOISE: assert property (@(posedge clk) disable iff (!arst_n)
		(uart && sio_tick && s_reg.rx_st == RX_START && s_reg.rx_cnt == `BIT_LAST
		&& maj3(s_reg.vote)) |=> s_reg.rx_st == RX_IDLE)
		else $error("noisy start bit was accepted");
	AST_OVERRUN_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
		(rx_take && s_reg.full && !rd_data) |=> s_reg.ovr && $stable(s_reg.rbuf)
		&& $stable(s_reg.ninth))
		else $error("overrun did not keep the buffer");
	AST_RX_EVENT: assert property (@(posedge clk) disable iff (!arst_n)
		(rx_take && !s_reg.full) |=> receive_interrupt && s_reg.full ##1 !receive_interrupt)
		else $error("receive event not one pulse with buffer full");
	AST_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
		(receive_interrupt && s_reg.mode == MODE_UART9 && s_reg.wake_filt) |-> s_reg.ninth)
		else $error("wake-up filter passed a ninth bit of zero");
	AST_RTS_DROP: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_data && !rx_done) |=> !rts)
		else $error("request line stayed high after data read");
	AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_ctrl && !sio_tick) |=> !s_reg.ovr && !s_reg.par_err && !s_reg.ferr)
		else $error("error flags survived control read");
	AST_CTS_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(s_reg.tx_busy) |-> !$past(s_reg.cts_s2))
		else $error("frame started while clear-to-send high");
	AST_TX_DONE: assert property (@(posedge clk) disable iff (!arst_n)
		(transmit_interrupt && uart) |-> !s_reg.tx_busy && txd)
		else $error("transmit event before the frame ended");
	COV_OVERRUN: cover property (@(posedge clk) disable iff (!arst_n) rx_take && s_reg.full);
	COV_WAKE_SKIP: cover property (@(posedge clk) disable iff (!arst_n) rx_done && !rx_take);
	COV_CTS_HALT: cover property (@(posedge clk) disable iff (!arst_n)
		tx_bit_clk && s_reg.tx_pend && s_reg.cts_s2 && !s_reg.tx_busy);
	COV_IO_DONE: cover property (@(posedge clk) disable iff (!arst_n)
		!uart && receive_interrupt && transmit_interrupt);
endmodule
`default_nettype wire

//--- dv/remote_uart.sv
// Far-side model: remote serial port and external shift register
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
	// Clock
	input wire logic clk,
	// Lines from the channel
	input wire logic txd,
	input wire logic sclk,
	// Lines toward the channel
	output logic rxd,
	output logic cts
);
	int bt = 32; // Bit time in clk cycles
	int nb = 8; // Bits heard after the start bit, stop excluded
	bit uart_on = 1'b0; // Listen for frames only when asked
	logic [9:0] frame = '0; // Last frame heard, stop bit on top
	int nfr = 0; // Frames heard
	logic [7:0] io_q = '0; // Byte heard in shift mode
	int io_n = 0; // Shift clock rising edges seen
	time t0 = 0; // First and last shift clock edge
	time tl = 0;
	// Idle mark on the line, sender free to go
	initial begin
		rxd = 1'b1;
		cts = 1'b0;
	end
	// Start bit, n bits LSB first, then two idle bit times between frames
	task automatic send(input logic [10:0] bits, input int n);
		rxd <= 1'b0;
		repeat (bt) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxd <= bits[i];
			repeat (bt) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (2 * bt) @(posedge clk);
	endtask
	// Sample mid-cell; a wrong bit rate shows up as a garbled frame
	always begin
		@(posedge clk);
		if (uart_on && txd === 1'b0) begin
			frame = '0;
			repeat (bt / 2) @(posedge clk);
			for (int i = 0; i <= nb; i++) begin
				repeat (bt) @(posedge clk);
				frame[i] = txd;
			end
			nfr++;
		end
	end
	// Data changes on the rising shift edge, so look half a cycle later
	always @(posedge sclk) begin
		@(negedge clk);
		if (io_n == 0) t0 = $time;
		tl = $time;
		io_q = {txd, io_q[7:1]};
		io_n++;
	end
endmodule
`default_nettype wire

//--- dv/tb_serial_channel_uart_core.sv
// Self-checking bench for the serial channel core
`include "serial_channel_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_serial_channel_uart_core import serial_channel_pkg::*;;
	logic clk = 1'b0; // 100 MHz
	logic arst_n = 1'b0; // Held low at start
	bus_req_t bus_req = '0; // Register port
	logic timer2_match = 1'b0; // Timer tick every third cycle
	logic [7:0] rdata;
	wire logic rxd;
	wire logic cts;
	logic txd, sclk, rts, rx_int, tx_int;
	int errors = 0;
	int num_checks = 0;
	int n_rx = 0; // Event pulses seen
	int n_tx = 0;
	int nfr_seen = 0; // Frames already compared
	int cyc = 0;
	bit rd_seen = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic [31:0] seed = 32'h5ce9;
	logic [7:0] q_rd[$]; // Expected read data, oldest first
	logic [9:0] q_tx[$]; // Expected frames, oldest first
	// Clock select, rate field and resulting bit time per row
	localparam int clk_sel_tab[6] = '{1, 1, 1, 3, 2, 0};
	localparam int rate_tab[6] = '{3, 2, 1, 3, 0, 0};
	localparam int bt_tab[6] = '{64, 256, 1024, 128, 32, 48};
	always #5 clk = ~clk;
	serial_channel_uart_core dut_u (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
		.rdata(rdata), .rxd(rxd), .cts(cts), .txd(txd), .sclk(sclk), .rts(rts),
		.timer2_match(timer2_match), .receive_interrupt(rx_int),
		.transmit_interrupt(tx_int));
	remote_uart far_u (.clk(clk), .txd(txd), .sclk(sclk), .rxd(rxd), .cts(cts));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Timer ticks; a cycle ceiling cuts a hang short
	always @(posedge clk) begin
		tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
		timer2_match <= (tcnt == 2'h2);
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end
	// Watcher: pairs each read and each heard frame with the oldest note
	always @(negedge clk) begin
		if (rd_seen)
			cmp(16'(rdata), 16'(q_rd.pop_front()), "read");
		rd_seen = bus_req.rd;
		if (far_u.nfr != nfr_seen) begin
			nfr_seen = far_u.nfr;
			cmp(16'(far_u.frame), 16'(q_tx.pop_front()), "frame");
		end
		if (rx_int === 1'b1) n_rx++;
		if (tx_int === 1'b1) n_tx++;
	end
	// One-cycle strobes, one idle cycle between requests
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		q_rd.push_back(exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 40000 && nfr_seen < n; i++) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	// Send one byte and expect its frame, then the transmit event
	task automatic tx(input logic [7:0] d, input logic [9:0] exp);
		int k0;
		k0 = n_tx;
		q_tx.push_back(exp);
		wr(`OFF_DATA, d);
		wait_tx(nfr_seen + 1);
		repeat (far_u.bt) @(posedge clk);
		cmp(16'(n_tx - k0), 16'd1, "tx event");
	endtask
	// Remote sends a frame; count receive events it caused
	task automatic rxf(input logic [10:0] b, input int ev);
		int k0;
		k0 = n_rx;
		far_u.send(b, 10);
		cmp(16'(n_rx - k0), 16'(ev), "rx event");
	endtask
	// Main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] d2;
		logic p;
		int k0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00);
		wr(`OFF_CTRL, 8'hff);
		wr(3'h5, 8'hff);
		rd(`OFF_CTRL, 8'h61);
		rd(3'h5, 8'h00);
		$display("test registers done");
		far_u.uart_on = 1'b1;
		wr(`OFF_CTRL, 8'h00);
		for (int k = 0; k < 6; k++) begin
			wr(`OFF_RATE, 8'(rate_tab[k] << 6));
			wr(`OFF_MODE, 8'(8'h08 | clk_sel_tab[k]));
			far_u.bt = bt_tab[k];
			seed = lfsr(seed);
			tx(seed[7:0], {2'b01, seed[7:0]});
		end
		$display("test rates done");
		far_u.bt = 32;
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			wr(`OFF_CTRL, k[0] ? 8'h60 : 8'h20);
			wr(`OFF_MODE, k[1] ? 8'h0a : 8'h06);
			far_u.nb = k[1] ? 9 : 8;
			p = k[1] ? ^d : ^d[6:0];
			if (!k[0]) p = ~p;
			tx(d, k[1] ? {1'b1, p, d} : {2'b01, p, d[6:0]});
		end
		wr(`OFF_MODE, 8'h8e);
		tx(d, {2'b11, d});
		$display("test transmit parity done");
		wr(`OFF_MODE, 8'h4a);
		wr(`OFF_CTRL, 8'h60);
		seed = lfsr(seed);
		d = seed[7:0];
		p = ^d;
		rxf({2'b01, p, d}, 1);
		rd(`OFF_CTRL, {p, 7'h60});
		rd(`OFF_DATA, d);
		rxf({2'b01, ~p, d}, 1);
		rd(`OFF_CTRL, {~p, 7'h68});
		rd(`OFF_CTRL, {~p, 7'h60});
		rd(`OFF_DATA, d);
		rxf({2'b00, p, d}, 1);
		rd(`OFF_CTRL, {p, 7'h64});
		rd(`OFF_DATA, d);
		d2 = ~d;
		rxf({2'b01, p, d}, 1);
		rxf({2'b01, p, d2}, 0);
		rd(`OFF_CTRL, {p, 7'h70});
		rd(`OFF_DATA, d);
		k0 = n_rx;
		far_u.rxd <= 1'b0;
		repeat (4) @(posedge clk);
		far_u.rxd <= 1'b1;
		repeat (400) @(posedge clk);
		cmp(16'(n_rx - k0), 16'd0, "noise start");
		$display("test receive done");
		wr(`OFF_CTRL, 8'h00);
		wr(`OFF_MODE, 8'h5e);
		rxf({3'b010, d2}, 0);
		rxf({3'b011, d}, 1);
		rd(`OFF_CTRL, 8'h80);
		rd(`OFF_DATA, d);
		wr(`OFF_MODE, 8'h4a);
		wr(`OFF_CTRL, 8'h01);
		cmp(16'(rts), 16'd0, "rts idle");
		rxf({3'b011, d2}, 1);
		cmp(16'(rts), 16'd1, "rts raised");
		rd(`OFF_DATA, d2);
		repeat (2) @(posedge clk);
		cmp(16'(rts), 16'd0, "rts lowered");
		$display("test wake-up and handshake done");
		wr(`OFF_CTRL, 8'h00);
		wr(`OFF_MODE, 8'h0a);
		far_u.nb = 8;
		far_u.cts <= 1'b1;
		k0 = nfr_seen;
		seed = lfsr(seed);
		q_tx.push_back({2'b01, seed[7:0]});
		wr(`OFF_DATA, seed[7:0]);
		repeat (640) @(posedge clk);
		cmp(16'(nfr_seen - k0), 16'd0, "held by cts");
		far_u.cts <= 1'b0;
		wait_tx(k0 + 1);
		cmp(16'(nfr_seen - k0), 16'd1, "resumed");
		$display("test clear-to-send done");
		far_u.uart_on = 1'b0;
		wr(`OFF_MODE, 8'h00);
		far_u.io_n = 0;
		k0 = n_tx;
		seed = lfsr(seed);
		wr(`OFF_DATA, seed[7:0]);
		for (int i = 0; i < 300 && n_tx == k0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		cmp(16'(far_u.io_q), 16'(seed[7:0]), "shift byte");
		cmp(16'(far_u.io_n), 16'd8, "shift edges");
		cmp(16'((far_u.tl - far_u.t0) / 10), 16'd56, "shift period");
		$display("test shift mode done");
		report_and_stop();
	end
endmodule
`default_nettype wire
